// ===== rtw_count_src.sv
`default_nettype none

// ==========================================================================
// Shared constants and carriers
package rtw_pkg;
  localparam int CNT_W = 8;
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_WAVE = 2'h1;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  localparam logic [1:0] MODE_WAIT = 2'h3;
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_NEIGH = 2'h2;
  localparam logic [1:0] SRC_F2 = 2'h3;
  localparam logic [7:0] RST_VALUE = 8'h00;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [2:0] DIV_F8_LAST = 3'h7;
  localparam logic [2:0] DIV_ONE = 3'h1;

  typedef struct packed {
    logic pre_wr;
    logic [7:0] pre_data;
    logic pri_wr;
    logic [7:0] pri_data;
    logic sec_wr;
    logic [7:0] sec_data;
  } rtw_wr_t;

  typedef struct packed {
    logic counting;
    logic oneshot_active;
    logic secondary_phase;
    logic [7:0] pre_count;
    logic [7:0] main_count;
  } rtw_status_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_PRIMARY = 2'b01,
    PH_SECONDARY = 2'b10
  } rtw_phase_t;
endpackage

// ==========================================================================
// Count source selector: peripheral taps or neighbour underflow
module rtw_count_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] sel,
  input wire logic neighbour_uf,
  output logic tick
);
  logic [2:0] div_q;

  // Free running divider; taps are one-cycle enables, not derived clocks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_q <= rtw_pkg::DIV_RST;
    else
      div_q <= div_q + rtw_pkg::DIV_ONE;
  end

  // Tap select
  always_comb
  begin
    case (sel)
      rtw_pkg::SRC_F1: tick = 1'b1;
      rtw_pkg::SRC_F8: tick = (div_q == rtw_pkg::DIV_F8_LAST);
      rtw_pkg::SRC_NEIGH: tick = neighbour_uf;
      rtw_pkg::SRC_F2: tick = div_q[0];
      default: tick = 1'b0;
    endcase
  end
endmodule

`default_nettype wire

// ===== rtw_far_side.sv
`default_nettype none

// ==========================================================================
// Far side: drives the trigger pin and measures each run of the pulse pin
module rtw_far_side (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic fire,
  input wire logic rising,
  output logic trig,
  output logic done,
  output logic lvl,
  output logic [15:0] len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_q;
  logic prev_q;
  logic [15:0] cnt_q;

  // Active level held four cycles so the synchroniser cannot miss it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hold_q <= 3'h0;
    else if (fire)
      hold_q <= 3'h4;
    else if (hold_q != 3'h0)
      hold_q <= hold_q - 3'h1;
  end
  assign trig = (hold_q != 3'h0) ? rising : ~rising;

  // Run meter: counts samples of one level, reports when the level flips
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_q <= 1'h0;
      cnt_q <= 16'h0001;
    end
    else
    begin
      prev_q <= pin;
      cnt_q <= (pin != prev_q) ? 16'h0001 : cnt_q + 16'h0001;
    end
  end
  assign done = (pin != prev_q);
  assign lvl = prev_q;
  assign len = cnt_q;
endmodule

`default_nettype wire

// ===== rtw_timer.sv
`default_nettype none

// Behaviour
// - Prescaler and main counter are both 8-bit down-counters.
// - Mode 00 timer, 01 waveform, 10 one-shot, 11 wait one-shot (code 11 runs as plain timer here).
// - Timer mode while counting: select 0 writes reload and counter, 1 reload only.
// - Each stage has reload and counter; main decrements per prescaler underflow.
// - Prescale value reaches its counter only on a count source edge.
// - Main value reaches its counter only on a prescaler underflow.
// - Four count sources: three clock taps and the neighbour timer underflow.
// - Waveform: output inverts at each underflow; primary and secondary reload alternately.
// - Waveform: after start the primary value counts first, then secondary.
// - Waveform periods are (pre+1)(primary+1) and (pre+1)(secondary+1) source cycles.
// - Start bit 1 starts; start 0 or forced stop halts counting.
// - Waveform interrupt follows the secondary-ending underflow, with the output change.
// - Waveform writes hit reload and counter when stopped, reload only when counting.
// - Waveform: new values show from the primary period after the primary write.
// - Output level bit sets polarity of primary and secondary periods.
// - Output switch picks waveform or port latch; applied at start or interrupt.
// - One-shot: each trigger gives one (pre+1)(primary+1) pulse; secondary unused.
// - One-shot underflow reloads counter, ends pulse, clears active flag.
// - One-shot: counter reloads from reload register whenever counting halts.
// - One-shot: with start set, software or pin edge trigger starts a pulse.
// - One-shot ends on underflow reload, one-shot stop, start cleared, forced stop.
// - One-shot interrupt follows the underflow, with the pulse end.
// - Pin acts as trigger only while pin trigger enable is 1.
// - One-shot writes while counting hit reload only, used at next reload.
module rtw_timer (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] MODE,
  input wire logic [1:0] COUNT_SOURCE_SEL,
  input wire logic WRITE_PATH_SELECT,
  input wire logic COUNT_START_BIT,
  input wire logic FORCED_STOP_BIT,
  input wire logic OUTPUT_LEVEL_BIT,
  input wire logic OUTPUT_SWITCH_BIT,
  input wire logic PIN_TRIGGER_ENABLE,
  input wire logic TRIGGER_RISING,
  input wire logic ONESHOT_START_BIT,
  input wire logic ONESHOT_STOP_BIT,
  input wire logic PORT_LATCH,
  input wire logic NEIGHBOUR_UNDERFLOW,
  input wire logic EXTERNAL_TRIGGER_PIN,
  input wire rtw_pkg::rtw_wr_t WRITES,
  output logic PULSE_OUTPUT_PIN,
  output logic TIMER_IRQ,
  output rtw_pkg::rtw_status_t STATUS
);
  logic tick;
  logic [7:0] pre_rl_q;
  logic [7:0] pri_rl_q;
  logic [7:0] sec_rl_q;
  logic [7:0] sec_act_q;
  logic [7:0] pre_cnt_q;
  logic [7:0] main_cnt_q;
  logic pre_pend_q;
  logic main_pend_q;
  logic run_q;
  logic fstop_hold_q;
  logic os_active_q;
  logic evt_q;
  logic evt_sec_q;
  logic irq_q;
  logic wave_q;
  logic wave_d;
  logic pin_q;
  logic sw_q;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  rtw_pkg::rtw_phase_t phase_q;
  logic run_now;
  logic start_evt;
  logic stop_evt;
  logic is_wave;
  logic is_os;
  logic cnt_en;
  logic pre_uf;
  logic main_uf;
  logic trigger;
  logic os_end;
  logic os_halt;
  logic prim_lvl;
  logic is_tmr;

  // ========================================================================
  // Count source
  rtw_count_src u_src (
    .clk(CLK),
    .rst(RST),
    .sel(COUNT_SOURCE_SEL),
    .neighbour_uf(NEIGHBOUR_UNDERFLOW),
    .tick(tick)
  );

  // ========================================================================
  // Start, stop and trigger decode
  assign is_wave = (MODE == rtw_pkg::MODE_WAVE);
  assign is_os = (MODE == rtw_pkg::MODE_ONESHOT);
  // Wait one-shot is outside this block, so its code runs as plain timer
  assign is_tmr = (MODE == rtw_pkg::MODE_TIMER) || (MODE == rtw_pkg::MODE_WAIT);
  // Forced stop holds until software drops the start bit, so a stale 1 cannot restart
  assign run_now = COUNT_START_BIT && !FORCED_STOP_BIT && !fstop_hold_q;
  assign start_evt = run_now && !run_q;
  assign stop_evt = run_q && !run_now;
  assign cnt_en = run_q && tick && (!is_os || os_active_q);
  assign pre_uf = cnt_en && !pre_pend_q && (pre_cnt_q == rtw_pkg::RST_VALUE);
  assign main_uf = pre_uf && !main_pend_q && (main_cnt_q == rtw_pkg::RST_VALUE);
  // Third stage only feeds the edge detector; first stage is read by the second alone
  assign trigger = ONESHOT_START_BIT || (PIN_TRIGGER_ENABLE &&
                   (TRIGGER_RISING ? (trig_s2_q && !trig_s3_q) : (!trig_s2_q && trig_s3_q)));
  assign os_end = ONESHOT_STOP_BIT || stop_evt || main_uf;
  assign os_halt = is_os && os_end;
  assign prim_lvl = !OUTPUT_LEVEL_BIT;

  // Pin synchroniser
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= EXTERNAL_TRIGGER_PIN;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // Run state and forced stop hold
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      run_q <= 1'b0;
      fstop_hold_q <= 1'b0;
    end
    else
    begin
      run_q <= run_now;
      if (FORCED_STOP_BIT)
        fstop_hold_q <= 1'b1;
      else if (!COUNT_START_BIT)
        fstop_hold_q <= 1'b0;
    end
  end

  // One-shot active flag; a trigger while active is dropped
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      os_active_q <= 1'b0;
    else if (!is_os || os_end)
      os_active_q <= 1'b0;
    else if (run_q && trigger && !os_active_q)
      os_active_q <= 1'b1;
  end

  // ========================================================================
  // Reload registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pre_rl_q <= rtw_pkg::RST_VALUE;
      pri_rl_q <= rtw_pkg::RST_VALUE;
      sec_rl_q <= rtw_pkg::RST_VALUE;
    end
    else
    begin
      if (WRITES.pre_wr)
        pre_rl_q <= WRITES.pre_data;
      if (WRITES.pri_wr)
        pri_rl_q <= WRITES.pri_data;
      if (WRITES.sec_wr)
        sec_rl_q <= WRITES.sec_data;
    end
  end

  // Pending counter loads for timer-mode writes that reach the counters too
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pre_pend_q <= 1'b0;
      main_pend_q <= 1'b0;
    end
    else if (!run_q || start_evt)
    begin
      pre_pend_q <= 1'b0;
      main_pend_q <= 1'b0;
    end
    else
    begin
      if (is_tmr && !WRITE_PATH_SELECT && WRITES.pre_wr)
        pre_pend_q <= 1'b1;
      else if (cnt_en)
        pre_pend_q <= 1'b0;
      if (is_tmr && !WRITE_PATH_SELECT && WRITES.pri_wr)
        main_pend_q <= 1'b1;
      else if (pre_uf)
        main_pend_q <= 1'b0;
    end
  end

  // ========================================================================
  // Prescaler counter
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      pre_cnt_q <= rtw_pkg::RST_VALUE;
    else if (start_evt || os_halt)
      pre_cnt_q <= pre_rl_q;
    else if (!run_q)
    begin
      if (WRITES.pre_wr)
        pre_cnt_q <= WRITES.pre_data;
    end
    else if (cnt_en)
    begin
      if (pre_pend_q || pre_cnt_q == rtw_pkg::RST_VALUE)
        pre_cnt_q <= pre_rl_q;
      else
        pre_cnt_q <= pre_cnt_q - 8'h01;
    end
  end

  // Main counter; waveform alternates primary and secondary reloads
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      main_cnt_q <= rtw_pkg::RST_VALUE;
    else if (start_evt || os_halt)
      main_cnt_q <= pri_rl_q;
    else if (!run_q)
    begin
      if (WRITES.pri_wr)
        main_cnt_q <= WRITES.pri_data;
    end
    else if (pre_uf)
    begin
      if (main_pend_q)
        main_cnt_q <= pri_rl_q;
      else if (main_cnt_q != rtw_pkg::RST_VALUE)
        main_cnt_q <= main_cnt_q - 8'h01;
      else if (is_wave && phase_q == rtw_pkg::PH_PRIMARY)
        main_cnt_q <= sec_act_q;
      else
        main_cnt_q <= pri_rl_q;
    end
  end

  // Secondary value is captured at each primary start, so new values begin there
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      sec_act_q <= rtw_pkg::RST_VALUE;
    else if (!run_q && WRITES.sec_wr)
      sec_act_q <= WRITES.sec_data;
    else if (start_evt || (main_uf && phase_q == rtw_pkg::PH_SECONDARY))
      sec_act_q <= sec_rl_q;
  end

  // ========================================================================
  // Waveform phase
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      phase_q <= rtw_pkg::PH_IDLE;
    else
    begin
      case (phase_q)
        rtw_pkg::PH_IDLE:
          if (start_evt && is_wave)
            phase_q <= rtw_pkg::PH_PRIMARY;
        rtw_pkg::PH_PRIMARY:
          if (!run_now || !is_wave)
            phase_q <= rtw_pkg::PH_IDLE;
          else if (main_uf)
            phase_q <= rtw_pkg::PH_SECONDARY;
        rtw_pkg::PH_SECONDARY:
          if (!run_now || !is_wave)
            phase_q <= rtw_pkg::PH_IDLE;
          else if (main_uf)
            phase_q <= rtw_pkg::PH_PRIMARY;
        default:
          phase_q <= rtw_pkg::PH_IDLE;
      endcase
    end
  end

  // Underflow event, delayed one clock to stand in for the half source cycle
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      evt_q <= 1'b0;
      evt_sec_q <= 1'b0;
    end
    else
    begin
      evt_q <= main_uf && run_now;
      evt_sec_q <= (phase_q == rtw_pkg::PH_SECONDARY);
    end
  end

  // ========================================================================
  // Output level
  always_comb
  begin
    wave_d = wave_q;
    if (is_wave)
    begin
      if (start_evt)
        wave_d = prim_lvl;
      else if (!run_q)
        wave_d = !prim_lvl;
      else if (evt_q)
        wave_d = !wave_q;
    end
    else if (is_os)
    begin
      // Underflow end waits for the active flag to drop, so pin and interrupt move together
      if (!os_active_q || (os_end && !main_uf))
        wave_d = !prim_lvl;
      else
        wave_d = prim_lvl;
    end
    else
      wave_d = !prim_lvl;
  end

  // Output switch is sampled only at start and at an interrupt
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      sw_q <= 1'b0;
    else if (start_evt || irq_q)
      sw_q <= OUTPUT_SWITCH_BIT;
  end

  // Pin and interrupt move on the same edge
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      wave_q <= 1'b1;
      pin_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      wave_q <= wave_d;
      pin_q <= (is_tmr || sw_q) ? PORT_LATCH : wave_d;
      irq_q <= evt_q && (!is_wave || evt_sec_q);
    end
  end

  // ========================================================================
  // Outputs
  assign PULSE_OUTPUT_PIN = pin_q;
  assign TIMER_IRQ = irq_q;
  assign STATUS = '{counting: run_q, oneshot_active: os_active_q,
                    secondary_phase: (phase_q == rtw_pkg::PH_SECONDARY),
                    pre_count: pre_cnt_q, main_count: main_cnt_q};

  // ========================================================================
  // Checks
  sequence s_wave_uf;
    main_uf && is_wave && run_now;
  endsequence

  sequence s_trig_while_active;
    os_active_q && trigger && !os_end;
  endsequence

  AST_PRE_RELOAD: assert property (@(posedge CLK) disable iff (RST)
    pre_uf && !os_halt && !start_evt |=> pre_cnt_q == $past(pre_rl_q))
    else $error("prescaler did not reload on underflow");

  AST_MAIN_DEC: assert property (@(posedge CLK) disable iff (RST)
    pre_uf && !main_pend_q && main_cnt_q != 8'h00 && !os_halt && !start_evt
    |=> main_cnt_q == $past(main_cnt_q) - 8'h01)
    else $error("main counter did not step on prescaler underflow");

  AST_PRE_SYNC: assert property (@(posedge CLK) disable iff (RST)
    run_q && !tick && !start_evt && !os_halt |=> $stable(pre_cnt_q))
    else $error("prescaler changed without a count source edge");

  AST_MAIN_SYNC: assert property (@(posedge CLK) disable iff (RST)
    run_q && !pre_uf && !start_evt && !os_halt |=> $stable(main_cnt_q))
    else $error("main counter changed without a prescaler underflow");

  AST_WAVE_TOGGLE: assert property (@(posedge CLK) disable iff (RST)
    s_wave_uf ##1 (run_q && run_now && is_wave) |=> wave_q != $past(wave_q))
    else $error("waveform did not invert after underflow");

  AST_WAVE_PRIMARY_FIRST: assert property (@(posedge CLK) disable iff (RST)
    start_evt && is_wave |=> phase_q == rtw_pkg::PH_PRIMARY && main_cnt_q == $past(pri_rl_q))
    else $error("waveform did not begin with the primary value");

  AST_WAVE_IRQ: assert property (@(posedge CLK) disable iff (RST)
    irq_q && is_wave |-> $past(evt_sec_q, 1) && $past(evt_q, 1))
    else $error("waveform interrupt without a secondary underflow");

  AST_FORCED_STOP: assert property (@(posedge CLK) disable iff (RST)
    FORCED_STOP_BIT |=> !run_q ##1 (!run_q || !COUNT_START_BIT || $past(!COUNT_START_BIT)))
    else $error("forced stop did not halt counting");

  AST_OS_END: assert property (@(posedge CLK) disable iff (RST)
    main_uf && is_os |=> !os_active_q && main_cnt_q == $past(pri_rl_q))
    else $error("one-shot underflow did not reload and clear active");

  AST_NO_RETRIGGER: assert property (@(posedge CLK) disable iff (RST)
    s_trig_while_active |=> os_active_q && $stable(main_cnt_q) || $past(pre_uf))
    else $error("active one-shot was retriggered");
endmodule

`default_nettype wire

// ===== tb.sv
`default_nettype none

// ==========================================================================
// Testbench for the reload timer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, wr_path = 1'h0, start = 1'h0, fstop = 1'h0;
  logic out_level = 1'h0, out_switch = 1'h0, pin_en = 1'h0, trig_rise = 1'h1;
  logic os_start = 1'h0, os_stop = 1'h0, port_latch = 1'h0, nb_uf = 1'h0, pin_fire = 1'h0;
  logic [1:0] mode = 2'h0, src_sel = 2'h0, nb_cnt = 2'h0;
  logic ext_pin, pulse_pin, irq, done, lvl, found;
  logic [15:0] len;
  logic [17:0] runs_q[$];
  rtw_pkg::rtw_wr_t wr = '0;
  rtw_pkg::rtw_status_t status;
  int miscompares = 0, n_tests = 0, cyc = 0;

  rtw_timer rtw_timer_i (.CLK(clk), .RST(rst), .MODE(mode), .COUNT_SOURCE_SEL(src_sel),
    .WRITE_PATH_SELECT(wr_path), .COUNT_START_BIT(start), .FORCED_STOP_BIT(fstop),
    .OUTPUT_LEVEL_BIT(out_level), .OUTPUT_SWITCH_BIT(out_switch), .PIN_TRIGGER_ENABLE(pin_en),
    .TRIGGER_RISING(trig_rise), .ONESHOT_START_BIT(os_start), .ONESHOT_STOP_BIT(os_stop),
    .PORT_LATCH(port_latch), .NEIGHBOUR_UNDERFLOW(nb_uf), .EXTERNAL_TRIGGER_PIN(ext_pin),
    .WRITES(wr), .PULSE_OUTPUT_PIN(pulse_pin), .TIMER_IRQ(irq), .STATUS(status));
  rtw_far_side rtw_far_side_i (.clk(clk), .rst(rst), .pin(pulse_pin), .fire(pin_fire),
    .rising(trig_rise), .trig(ext_pin), .done(done), .lvl(lvl), .len(len));

  // ==========================================================================
  // Clock, neighbour underflow every 4th cycle, run log and hang guard
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    nb_cnt <= nb_cnt + 2'h1;
    nb_uf <= (nb_cnt == 2'h3);
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  // Logged at the falling edge so the meter's update has settled
  always @(negedge clk)
  begin
    if (done)
      runs_q.push_back({irq, lvl, len});
  end

  // ==========================================================================
  // Access tasks
  task automatic check(input string nm, input logic [20:0] exp, input logic [20:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input int r, input logic [7:0] d);
    @(posedge clk);
    wr <= {r == 0, d, r == 1, d, r == 2, d};
    @(posedge clk);
    wr <= '0;
  endtask
  // One-cycle strobes: 0 trigger, 1 one-shot stop, 2 forced stop, 3 pin edge
  task automatic strobe(input int k);
    @(posedge clk);
    case (k)
      0: os_start <= 1'h1;
      1: os_stop <= 1'h1;
      2: fstop <= 1'h1;
      default: pin_fire <= 1'h1;
    endcase
    @(posedge clk);
    os_start <= 1'h0;
    os_stop <= 1'h0;
    fstop <= 1'h0;
    pin_fire <= 1'h0;
  endtask
  task automatic wait_runs(input int n);
    int k;
    k = 0;
    while (runs_q.size() < n && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic wait_main(input logic [7:0] v, input int n);
    found = 1'h0;
    repeat (n)
    begin
      @(negedge clk);
      if (status.main_count === v)
        found = 1'h1;
    end
  endtask
  task automatic run_start(input logic v);
    @(posedge clk);
    start <= v;
    tick(3);
  endtask
  // Pulse from trigger k must last exactly w cycles at the high level
  task automatic os_pulse(input int k, input logic [15:0] w);
    runs_q.delete();
    strobe(k);
    wait_runs(2);
    check("oneshot run", {2'h3, w}, runs_q[1]);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  logic [1:0] srcs[4] = '{rtw_pkg::SRC_F1, rtw_pkg::SRC_F8, rtw_pkg::SRC_F2, rtw_pkg::SRC_NEIGH};
  logic [15:0] divs[4] = '{16'h1, 16'h8, 16'h2, 16'h4};
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    tick(1);
    check("reset", 20'h0, {pulse_pin, irq, status});
    // Waveform with each count source, polarity alternating
    for (int i = 0; i < 4; i++)
    begin
      mode <= rtw_pkg::MODE_WAVE;
      src_sel <= srcs[i];
      out_level <= i[0];
      wr_reg(0, 8'h01);
      wr_reg(1, 8'h02);
      tick(1);
      check("stopped write", 16'h0102, {status.pre_count, status.main_count});
      wr_reg(2, 8'h03);
      run_start(1'h1);
      check("primary level", {19'h0, ~i[0]}, {19'h0, pulse_pin});
      runs_q.delete();
      wait_runs(3);
      check("secondary run", {1'h1, i[0], 16'h8 * divs[i]}, runs_q[1]);
      check("primary run", {1'h0, ~i[0], 16'h6 * divs[i]}, runs_q[2]);
      wr_reg(1, 8'h04);
      runs_q.delete();
      wait_runs(2);
      check("new primary", {1'h0, ~i[0], 16'hA * divs[i]}, runs_q[1]);
      run_start(1'h0);
      check("stopped", 20'h0, {19'h0, status.counting});
      $display("waveform source %0d done", i);
    end
    // Pin taken over by the port latch
    out_switch <= 1'h1;
    port_latch <= 1'h1;
    run_start(1'h1);
    check("port latch high", 20'h1, {19'h0, pulse_pin});
    port_latch <= 1'h0;
    tick(3);
    check("port latch low", 20'h0, {19'h0, pulse_pin});
    run_start(1'h0);
    out_switch <= 1'h0;
    $display("output switch done");
    // One-shot pulses
    mode <= rtw_pkg::MODE_ONESHOT;
    src_sel <= rtw_pkg::SRC_F1;
    out_level <= 1'h0;
    wr_reg(0, 8'h00);
    wr_reg(1, 8'h09);
    run_start(1'h1);
    os_pulse(0, 16'd10);
    check("after pulse", {11'h0, 1'h0, 8'h09}, {11'h0, status.oneshot_active, status.main_count});
    runs_q.delete();
    strobe(0);
    tick(4);
    strobe(0);
    wait_runs(2);
    check("no retrigger", {2'h3, 16'd10}, runs_q[1]);
    pin_en <= 1'h1;
    os_pulse(3, 16'd10);
    trig_rise <= 1'h0;
    tick(8);
    os_pulse(3, 16'd10);
    pin_en <= 1'h0;
    strobe(3);
    tick(8);
    check("pin ignored", 20'h0, {19'h0, status.oneshot_active});
    runs_q.delete();
    strobe(0);
    tick(4);
    wr_reg(1, 8'h05);
    wait_runs(2);
    check("old width", {2'h3, 16'd10}, runs_q[1]);
    os_pulse(0, 16'd6);
    for (int k = 1; k < 3; k++)
    begin
      strobe(0);
      tick(1);
      strobe(k);
      tick(3);
      check("aborted", {10'h0, k == 1, 1'h0, 8'h05},
        {10'h0, status.counting, status.oneshot_active, status.main_count});
      $display("oneshot abort %0d done", k);
    end
    run_start(1'h0);
    // Timer mode write path, also under the fourth mode code
    for (int m = 0; m < 2; m++)
    begin
      mode <= (m == 0) ? rtw_pkg::MODE_TIMER : rtw_pkg::MODE_WAIT;
      wr_path <= 1'h0;
      wr_reg(0, 8'h03);
      wr_reg(1, 8'h0A);
      run_start(1'h1);
      wr_reg(1, 8'h20);
      wait_main(8'h20, 10);
      check("direct write", 20'h1, {19'h0, found});
      wr_path <= 1'h1;
      wr_reg(1, 8'h40);
      wait_main(8'h40, 8);
      check("reload only", 20'h0, {19'h0, found});
      wait_main(8'h40, 200);
      check("reload used", 20'h1, {19'h0, found});
      run_start(1'h0);
      $display("timer mode %0d done", m);
    end
    complete_run();
  end
endmodule

`default_nettype wire
